// ==== rtl/cdh_pkg.sv ====
// cdh_pkg: shared constants and types for the card dma handshake ends
// assumes both ends run on a 100 MHz core clock
`default_nettype none
package cdh_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 8;
  localparam int CORE_MHZ = 100;
  // host i/o and multiword strobe width, least time
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CORE_MHZ + 999) / 1000;
  // half period of the host burst strobe, longest time
  localparam int BURST_HALF_NS = 80;
  localparam int BURST_HALF_CYC = (BURST_HALF_NS * CORE_MHZ) / 1000;
  localparam int BURST_MID_CYC = BURST_HALF_CYC / 2;
  localparam int GAP_CYC = 4;
  localparam logic [DATA_W-1:0] BUS_IDLE = 16'hFFFF;
  localparam logic [DATA_W-1:0] LOW_MASK = 16'h00FF;
  // positions of the host pins in the card's synchroniser vector
  localparam int SI_RD = 0;
  localparam int SI_WR = 1;
  localparam int SI_GNT = 2;
  localparam int SI_RDY = 3;
  localparam int SI_HSTB = 4;
  localparam int SI_STOP = 5;
  localparam int SI_TSEL = 6;
  localparam int SI_ASEL = 7;
  localparam int SI_CEL = 8;
  localparam int SI_CEH = 9;
  localparam int SYNC_N = 10;
  // idle level of each synchronised host pin, used as its reset value
  localparam logic [SYNC_N-1:0] SYNC_IDLE = 10'h3CF;
  typedef enum logic [1:0] {
    CDH_MEM = 2'h0,
    CDH_IO = 2'h1,
    CDH_DISK = 2'h2
  } cdh_mode_t;
endpackage
`default_nettype wire

// ==== rtl/cdh_if.sv ====
// cdh_if: card bus wires between the card end and the host end
// resolves the shared data bus and the releasable request line
`default_nettype none
interface cdh_if;
  import cdh_pkg::*;
  logic input_ack_n;
  logic req_o;
  logic req_oe_n;
  logic transfer_request;
  logic transfer_grant_n;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic host_burst_ready_n;
  logic host_burst_strobe;
  logic stop;
  logic task_select_n;
  logic aux_select_n;
  logic card_enable_low_n;
  logic card_enable_high_n;
  logic [DATA_W-1:0] card_data;
  logic card_data_oe_n;
  logic [DATA_W-1:0] host_data;
  logic host_data_oe_n;
  logic [DATA_W-1:0] data;
  // released request line is pulled low
  assign transfer_request = !req_oe_n ? req_o : 1'h0;
  assign data = !card_data_oe_n ? card_data : (!host_data_oe_n ? host_data : BUS_IDLE);
  modport card (
    output input_ack_n, req_o, req_oe_n, card_data, card_data_oe_n,
    input transfer_grant_n, io_read_strobe_n, io_write_strobe_n, host_burst_ready_n,
    input host_burst_strobe, stop, task_select_n, aux_select_n,
    input card_enable_low_n, card_enable_high_n, data
  );
  modport host (
    output transfer_grant_n, io_read_strobe_n, io_write_strobe_n, host_burst_ready_n,
    output host_burst_strobe, stop, task_select_n, aux_select_n,
    output card_enable_low_n, card_enable_high_n, host_data, host_data_oe_n,
    input input_ack_n, transfer_request, data
  );
endinterface
`default_nettype wire

// ==== rtl/cdh_card.sv ====
// cdh_card: card end of the host port handshake
// assumes host pins are asynchronous to core_clk; bus side via cdh_if.card
//
// How it works
// - io mode: acknowledge selected io reads at hit
// - host may ignore acknowledge, using enables only
// - raise request when ready to move data
// - hold request until grant; re-raise if more
// - host picks direction by strobe it pulses
// - host never starts io read during request
// - disk mode: release request when not selected
// - host keeps selects negated, full words
// - drive read data while read strobe low
// - host readies data-in bursts, may pause
// - capture burst word on both strobe edges
// - host may pause strobe; card waits
// - stop ends the current burst
// - io write data taken on trailing edge
// - disk task access uses low byte only
`default_nettype none
module cdh_card
  import cdh_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  cdh_if.card bus,
  input wire cdh_mode_t mode,
  input wire logic drive_selected,
  input wire logic udma_on,
  input wire logic io_addr_hit,
  input wire logic xfer_pending,
  input wire logic [DATA_W-1:0] rd_word,
  output logic [DATA_W-1:0] wr_word,
  output logic wr_valid,
  output logic task_access,
  output logic [DATA_W-1:0] burst_word,
  output logic burst_valid,
  output logic burst_stopped,
  output logic host_ready
);
  typedef enum logic [1:0] {
    REQ_IDLE = 2'h0,
    REQ_ON = 2'h1,
    REQ_HELD = 2'h2
  } cdh_req_t;

  // -------------------------------------------
  // synchronisers
  // -------------------------------------------
  logic [SYNC_N-1:0] s1_r, s2_r, s3_r;
  logic [SYNC_N-1:0] s1_nxt, s2_nxt, s3_nxt;
  logic [DATA_W-1:0] d1_r, d2_r, d1_nxt, d2_nxt;

  always_comb begin
    s1_nxt = {bus.card_enable_high_n, bus.card_enable_low_n, bus.aux_select_n, bus.task_select_n,
              bus.stop, bus.host_burst_strobe, bus.host_burst_ready_n, bus.transfer_grant_n,
              bus.io_write_strobe_n, bus.io_read_strobe_n};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    d1_nxt = bus.data;
    d2_nxt = d1_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
      s3_r <= SYNC_IDLE;
      d1_r <= BUS_IDLE;
      d2_r <= BUS_IDLE;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
    end
  end

  // -------------------------------------------
  // decoded host levels and edges
  // -------------------------------------------
  logic rd_on, grant, stop_on, task_on, selected, wr_rise, hstb_edge, stop_rise;
  assign rd_on = !s2_r[SI_RD];
  assign grant = !s2_r[SI_GNT];
  assign stop_on = s2_r[SI_STOP];
  assign task_on = (mode == CDH_DISK) && !s2_r[SI_TSEL] && !grant;
  assign wr_rise = s2_r[SI_WR] && !s3_r[SI_WR];
  assign hstb_edge = s2_r[SI_HSTB] ^ s3_r[SI_HSTB];
  assign stop_rise = s2_r[SI_STOP] && !s3_r[SI_STOP];

  always_comb begin
    if (mode == CDH_DISK) begin
      selected = !s2_r[SI_TSEL] || !s2_r[SI_ASEL] || grant;
    end else begin
      selected = !s2_r[SI_CEL] || !s2_r[SI_CEH] || grant;
    end
  end

  function automatic logic [DATA_W-1:0] low_only(input logic [DATA_W-1:0] w, input logic tf);
    low_only = tf ? (w & LOW_MASK) : w;
  endfunction

  // -------------------------------------------
  // request handshake and bus answers
  // -------------------------------------------
  cdh_req_t req_r, req_nxt;
  logic req_oe_n_r, req_oe_n_nxt;
  logic req_o_r, req_o_nxt;
  logic ack_n_r, ack_n_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic doe_n_r, doe_n_nxt;
  logic [DATA_W-1:0] wr_word_r, wr_word_nxt;
  logic wr_valid_r, wr_valid_nxt;
  logic task_r, task_nxt;
  logic [DATA_W-1:0] bw_r, bw_nxt;
  logic bv_r, bv_nxt;
  logic bs_r, bs_nxt;
  logic hr_r, hr_nxt;

  always_comb begin
    req_nxt = req_r;
    unique case (req_r)
      REQ_IDLE: begin
        if (xfer_pending) begin
          req_nxt = REQ_ON;
        end
      end
      REQ_ON: begin
        if (grant) begin
          req_nxt = REQ_HELD;
        end
      end
      REQ_HELD: begin
        if (!grant) begin
          req_nxt = REQ_IDLE;
        end
      end
      default: req_nxt = REQ_IDLE;
    endcase
    req_o_nxt = (req_nxt == REQ_ON);
    req_oe_n_nxt = (mode == CDH_DISK) && !drive_selected;
    ack_n_nxt = !((mode == CDH_IO) && !udma_on && selected && rd_on && io_addr_hit);
    doe_n_nxt = !(!udma_on && (mode != CDH_MEM) && selected && rd_on);
    dout_nxt = low_only(rd_word, task_on);
    task_nxt = task_on;
    wr_valid_nxt = 1'h0;
    wr_word_nxt = wr_word_r;
    if (!udma_on && (mode != CDH_MEM) && selected && wr_rise) begin
      wr_valid_nxt = 1'h1;
      wr_word_nxt = low_only(d2_r, task_on);
    end
    bv_nxt = 1'h0;
    bw_nxt = bw_r;
    if (udma_on && grant && !stop_on && hstb_edge) begin
      bv_nxt = 1'h1;
      bw_nxt = d2_r;
    end
    bs_nxt = udma_on && stop_rise;
    hr_nxt = udma_on && !s2_r[SI_RDY];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_r <= REQ_IDLE;
      req_o_r <= 1'h0;
      req_oe_n_r <= 1'h1;
      ack_n_r <= 1'h1;
      dout_r <= BUS_IDLE;
      doe_n_r <= 1'h1;
      wr_word_r <= '0;
      wr_valid_r <= 1'h0;
      task_r <= 1'h0;
      bw_r <= '0;
      bv_r <= 1'h0;
      bs_r <= 1'h0;
      hr_r <= 1'h0;
    end else begin
      req_r <= req_nxt;
      req_o_r <= req_o_nxt;
      req_oe_n_r <= req_oe_n_nxt;
      ack_n_r <= ack_n_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
      wr_word_r <= wr_word_nxt;
      wr_valid_r <= wr_valid_nxt;
      task_r <= task_nxt;
      bw_r <= bw_nxt;
      bv_r <= bv_nxt;
      bs_r <= bs_nxt;
      hr_r <= hr_nxt;
    end
  end

  // -------------------------------------------
  // outputs
  // -------------------------------------------
  // a held request is dropped only in REQ_HELD, after grant; pauses need no action
  assign bus.req_o = req_o_r;
  assign bus.req_oe_n = req_oe_n_r;
  assign bus.input_ack_n = ack_n_r;
  assign bus.card_data = dout_r;
  assign bus.card_data_oe_n = doe_n_r;
  assign wr_word = wr_word_r;
  assign wr_valid = wr_valid_r;
  assign task_access = task_r;
  assign burst_word = bw_r;
  assign burst_valid = bv_r;
  assign burst_stopped = bs_r;
  assign host_ready = hr_r;

endmodule // cdh_card
`default_nettype wire

// ==== rtl/cdh_host.sv ====
// cdh_host: host end driving the card bus
// assumes the card answers are asynchronous to core_clk; bus side via cdh_if.host
`default_nettype none
module cdh_host
  import cdh_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  cdh_if.host bus,
  input wire logic io_rd_req,
  input wire logic io_wr_req,
  input wire logic dma_rd_req,
  input wire logic dma_wr_req,
  input wire logic burst_req,
  input wire logic [CNT_W-1:0] burst_len,
  input wire logic burst_pause,
  input wire logic burst_stop_req,
  input wire logic rx_ok,
  input wire logic [DATA_W-1:0] wr_word,
  output logic word_take,
  output logic busy,
  output logic [DATA_W-1:0] rd_word,
  output logic rd_valid
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_IO = 3'h1,
    H_WAIT = 3'h2,
    H_DMA = 3'h3,
    H_BURST = 3'h4,
    H_STOP = 3'h5,
    H_GAP = 3'h6
  } cdh_hst_t;

  // -------------------------------------------
  // request synchroniser
  // -------------------------------------------
  logic q1_r, q2_r;
  logic [DATA_W-1:0] hq1_r, hq2_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q1_r <= 1'h0;
      q2_r <= 1'h0;
      hq1_r <= BUS_IDLE;
      hq2_r <= BUS_IDLE;
    end else begin
      q1_r <= bus.transfer_request;
      q2_r <= q1_r;
      hq1_r <= bus.data;
      hq2_r <= hq1_r;
    end
  end

  // -------------------------------------------
  // cycle sequencer
  // -------------------------------------------
  cdh_hst_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, left_r, left_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, gnt_r, gnt_nxt, cel_r, cel_nxt;
  logic hstb_r, hstb_nxt, stop_r, stop_nxt, dir_rd_r, dir_rd_nxt, bst_r, bst_nxt;
  logic [DATA_W-1:0] hd_r, hd_nxt, rw_r, rw_nxt;
  logic hoe_n_r, hoe_n_nxt, rv_r, rv_nxt, take_r, take_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 8'h01;
    left_nxt = left_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    gnt_nxt = gnt_r;
    cel_nxt = cel_r;
    hstb_nxt = hstb_r;
    stop_nxt = stop_r;
    dir_rd_nxt = dir_rd_r;
    bst_nxt = bst_r;
    hd_nxt = hd_r;
    hoe_n_nxt = hoe_n_r;
    rw_nxt = rw_r;
    rv_nxt = 1'h0;
    take_nxt = 1'h0;
    unique case (st_r)
      H_IDLE: begin
        cnt_nxt = '0;
        if (io_rd_req && !q2_r) begin
          st_nxt = H_IO;
          cel_nxt = 1'h0;
          rd_nxt = 1'h0;
          dir_rd_nxt = 1'h1;
        end else if (io_wr_req) begin
          st_nxt = H_IO;
          cel_nxt = 1'h0;
          wr_nxt = 1'h0;
          hd_nxt = wr_word;
          hoe_n_nxt = 1'h0;
          take_nxt = 1'h1;
          dir_rd_nxt = 1'h0;
        end else if (dma_rd_req || dma_wr_req || burst_req) begin
          st_nxt = H_WAIT;
          dir_rd_nxt = dma_rd_req;
          bst_nxt = burst_req && !dma_rd_req && !dma_wr_req;
        end
      end
      H_IO, H_DMA: begin
        if (cnt_r == 8'(STROBE_CYC - 1)) begin
          st_nxt = H_GAP;
          cnt_nxt = '0;
          rd_nxt = 1'h1;
          wr_nxt = 1'h1;
          if (dir_rd_r) begin
            rw_nxt = hq2_r;
            rv_nxt = 1'h1;
          end
        end
      end
      H_WAIT: begin
        cnt_nxt = '0;
        if (q2_r) begin
          gnt_nxt = 1'h0;
          if (bst_r) begin
            st_nxt = H_BURST;
            hd_nxt = wr_word;
            hoe_n_nxt = 1'h0;
            take_nxt = 1'h1;
            left_nxt = burst_len;
          end else begin
            st_nxt = H_DMA;
            rd_nxt = !dir_rd_r;
            wr_nxt = dir_rd_r;
            if (!dir_rd_r) begin
              hd_nxt = wr_word;
              hoe_n_nxt = 1'h0;
              take_nxt = 1'h1;
            end
          end
        end
      end
      H_BURST: begin
        if (cnt_r == 8'(BURST_HALF_CYC - 1)) begin
          if (burst_stop_req || left_r == '0) begin
            st_nxt = H_STOP;
            stop_nxt = 1'h1;
            cnt_nxt = '0;
          end else if (burst_pause) begin
            cnt_nxt = cnt_r;
          end else begin
            hstb_nxt = !hstb_r;
            left_nxt = left_r - 8'h01;
            cnt_nxt = '0;
          end
        end else if (cnt_r == 8'(BURST_MID_CYC) && left_r != burst_len && left_r != '0) begin
          hd_nxt = wr_word;
          take_nxt = 1'h1;
        end
      end
      H_STOP: begin
        if (cnt_r == 8'(BURST_HALF_CYC - 1)) begin
          st_nxt = H_GAP;
          cnt_nxt = '0;
          stop_nxt = 1'h0;
        end
      end
      H_GAP: begin
        cel_nxt = 1'h1;
        gnt_nxt = 1'h1;
        hoe_n_nxt = 1'h1;
        bst_nxt = 1'h0;
        if (cnt_r == 8'(GAP_CYC - 1)) begin
          st_nxt = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    busy_nxt = (st_nxt != H_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= H_IDLE;
      busy_r <= 1'h0;
      cnt_r <= '0;
      left_r <= '0;
      rd_r <= 1'h1;
      wr_r <= 1'h1;
      gnt_r <= 1'h1;
      cel_r <= 1'h1;
      hstb_r <= 1'h0;
      stop_r <= 1'h0;
      dir_rd_r <= 1'h0;
      bst_r <= 1'h0;
      hd_r <= BUS_IDLE;
      hoe_n_r <= 1'h1;
      rw_r <= '0;
      rv_r <= 1'h0;
      take_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      gnt_r <= gnt_nxt;
      cel_r <= cel_nxt;
      hstb_r <= hstb_nxt;
      stop_r <= stop_nxt;
      dir_rd_r <= dir_rd_nxt;
      bst_r <= bst_nxt;
      hd_r <= hd_nxt;
      hoe_n_r <= hoe_n_nxt;
      rw_r <= rw_nxt;
      rv_r <= rv_nxt;
      take_r <= take_nxt;
    end
  end

  logic rdy_n_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdy_n_r <= 1'h1;
    end else begin
      rdy_n_r <= !rx_ok;
    end
  end

  // -------------------------------------------
  // outputs
  // -------------------------------------------
  assign bus.io_read_strobe_n = rd_r;
  assign bus.io_write_strobe_n = wr_r;
  assign bus.transfer_grant_n = gnt_r;
  assign bus.host_burst_ready_n = rdy_n_r;
  assign bus.host_burst_strobe = hstb_r;
  assign bus.stop = stop_r;
  assign bus.task_select_n = 1'h1;
  assign bus.aux_select_n = 1'h1;
  assign bus.card_enable_low_n = cel_r;
  assign bus.card_enable_high_n = cel_r;
  assign bus.host_data = hd_r;
  assign bus.host_data_oe_n = hoe_n_r;
  assign word_take = take_r;
  assign busy = busy_r;
  assign rd_word = rw_r;
  assign rd_valid = rv_r;

endmodule // cdh_host
`default_nettype wire

// ==== tb/cdh_sva.sv ====
// cdh_sva: protocol assertions on the card bus wires
// assumes plain copies of the cdh_if signals and the card mode inputs
`default_nettype none
module cdh_sva
  import cdh_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire cdh_mode_t mode,
  input wire logic udma_on,
  input wire logic io_addr_hit,
  input wire logic drive_selected,
  input wire logic xfer_pending,
  input wire logic input_ack_n,
  input wire logic transfer_request,
  input wire logic req_oe_n,
  input wire logic transfer_grant_n,
  input wire logic io_read_strobe_n,
  input wire logic task_select_n,
  input wire logic aux_select_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  input wire logic card_data_oe_n,
  input wire logic host_burst_strobe,
  input wire logic stop
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ack_io;
    $fell(input_ack_n) |-> mode == CDH_IO && !io_read_strobe_n;
  endproperty
  a_ack_io: assert property (p_ack_io) else $error("ack outside io read");
  property p_ack_rd;
    $fell(io_read_strobe_n) && mode == CDH_IO && io_addr_hit && !udma_on |-> ##[2:4] !input_ack_n;
  endproperty
  a_ack_rd: assert property (p_ack_rd) else $error("io read not acknowledged");
  property p_drv;
    $fell(io_read_strobe_n) && mode == CDH_IO && !udma_on |-> ##[2:4] !card_data_oe_n;
  endproperty
  a_drv: assert property (p_drv) else $error("read data not driven");
  property p_no_mem;
    mode == CDH_MEM |-> card_data_oe_n;
  endproperty
  a_no_mem: assert property (p_no_mem) else $error("data driven in memory mode");
  property p_hold;
    transfer_request && transfer_grant_n |=> transfer_request || !drive_selected;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before grant");
  property p_drop;
    $fell(transfer_request) && !req_oe_n |-> !$past(transfer_grant_n, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("request fell without grant");
  property p_rise;
    $rose(xfer_pending) && (mode != CDH_DISK || drive_selected) && transfer_grant_n |-> ##[1:3] transfer_request;
  endproperty
  a_rise: assert property (p_rise) else $error("request not raised");
  property p_rel;
    mode == CDH_DISK && !drive_selected |=> req_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("request driven while deselected");
  property p_sel;
    !transfer_grant_n |-> task_select_n && aux_select_n && card_enable_low_n && card_enable_high_n;
  endproperty
  a_sel: assert property (p_sel) else $error("select low during dma");
  c_ack: cover property ($fell(input_ack_n));
  c_drop: cover property ($fell(transfer_request));
  c_hstb: cover property (!transfer_grant_n && $changed(host_burst_strobe));
  c_stop: cover property ($rose(stop));
endmodule // cdh_sva
`default_nettype wire

// ==== tb/cdh_tb_top.sv ====
// cdh_tb_top: card end and host end joined by cdh_if, driven from the user sides
// assumes cdh_pkg, cdh_if, cdh_card, cdh_host and cdh_sva are compiled first
`default_nettype none
module cdh_tb_top;
  import cdh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {cdh_mode_t m; logic hit; logic u; logic drv; logic ack;} cdh_row_t;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  cdh_mode_t mode = CDH_IO;
  logic drive_selected = 1'h1, udma_on = 1'h0, io_addr_hit = 1'h0, xfer_pending = 1'h0;
  logic [DATA_W-1:0] c_rd = 16'h0000, c_wr, b_word, h_rd, got_rd, taken;
  logic [DATA_W-1:0] h_wr = 16'h1234;
  logic c_wr_v, task_access, b_v, b_stop, host_ready, take, busy, h_rd_v, ack_seen;
  logic io_rd_req = 1'h0, io_wr_req = 1'h0, dma_rd_req = 1'h0, dma_wr_req = 1'h0, burst_req = 1'h0;
  logic [CNT_W-1:0] burst_len = 8'h01;
  logic burst_pause = 1'h0, burst_stop_req = 1'h0, rx_ok = 1'h1;
  logic [DATA_W-1:0] bq[$];
  int errors = 0, n_tests = 0, n_wr = 0, n_stop = 0, nb, snap;
  cdh_row_t rows[4] = '{'{CDH_MEM, 1'h1, 1'h0, 1'h0, 1'h0}, '{CDH_IO, 1'h1, 1'h0, 1'h1, 1'h1},
                        '{CDH_IO, 1'h0, 1'h0, 1'h1, 1'h0}, '{CDH_IO, 1'h1, 1'h1, 1'h0, 1'h0}};
  always #5 core_clk = ~core_clk;
  cdh_if cdh_if_i();
  cdh_card cdh_card_i (.core_clk(core_clk), .rst(rst), .bus(cdh_if_i), .mode(mode),
    .drive_selected(drive_selected), .udma_on(udma_on), .io_addr_hit(io_addr_hit), .xfer_pending(xfer_pending),
    .rd_word(c_rd), .wr_word(c_wr), .wr_valid(c_wr_v), .task_access(task_access), .burst_word(b_word),
    .burst_valid(b_v), .burst_stopped(b_stop), .host_ready(host_ready));
  cdh_host cdh_host_i (.core_clk(core_clk), .rst(rst), .bus(cdh_if_i), .io_rd_req(io_rd_req),
    .io_wr_req(io_wr_req), .dma_rd_req(dma_rd_req), .dma_wr_req(dma_wr_req), .burst_req(burst_req),
    .burst_len(burst_len), .burst_pause(burst_pause), .burst_stop_req(burst_stop_req), .rx_ok(rx_ok),
    .wr_word(h_wr), .word_take(take), .busy(busy), .rd_word(h_rd), .rd_valid(h_rd_v));
  cdh_sva cdh_sva_i (.core_clk(core_clk), .rst(rst), .mode(mode), .udma_on(udma_on), .io_addr_hit(io_addr_hit),
    .drive_selected(drive_selected), .xfer_pending(xfer_pending), .input_ack_n(cdh_if_i.input_ack_n),
    .transfer_request(cdh_if_i.transfer_request), .req_oe_n(cdh_if_i.req_oe_n),
    .transfer_grant_n(cdh_if_i.transfer_grant_n), .io_read_strobe_n(cdh_if_i.io_read_strobe_n),
    .task_select_n(cdh_if_i.task_select_n), .aux_select_n(cdh_if_i.aux_select_n),
    .card_data_oe_n(cdh_if_i.card_data_oe_n), .host_burst_strobe(cdh_if_i.host_burst_strobe),
    .card_enable_low_n(cdh_if_i.card_enable_low_n), .card_enable_high_n(cdh_if_i.card_enable_high_n),
    .stop(cdh_if_i.stop));
  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (h_rd_v === 1'h1) got_rd = h_rd;
    if (c_wr_v === 1'h1) n_wr++;
    if (b_v === 1'h1) bq.push_back(b_word);
    if (b_stop === 1'h1) n_stop++;
    if (cdh_if_i.input_ack_n === 1'h0) ack_seen = 1'h1;
  end
  // host consumes the offered word; next one differs by a fixed step
  always @(negedge core_clk) begin
    if (take === 1'h1) begin
      taken = h_wr;
      h_wr = h_wr + 16'h0111;
    end
  end
  task chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task run(input logic [4:0] sel);
    int k;
    {io_rd_req, io_wr_req, dma_rd_req, dma_wr_req, burst_req} = sel;
    @(negedge core_clk);
    {io_rd_req, io_wr_req, dma_rd_req, dma_wr_req, burst_req} = 5'h00;
    repeat (3) @(negedge core_clk);
    k = 0;
    while (busy !== 1'h0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    chk("busy", {15'h0000, busy}, 16'h0000);
    repeat (6) @(negedge core_clk);
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    chk("rst_req", {15'h0000, cdh_if_i.req_oe_n}, 16'h0001);
    rst = 1'h0;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      mode = rows[i].m;
      io_addr_hit = rows[i].hit;
      udma_on = rows[i].u;
      c_rd = 16'hC0D0 + 16'(i);
      ack_seen = 1'h0;
      got_rd = 16'h0000;
      run(5'h10);
      chk("io_rd", got_rd, rows[i].drv ? c_rd : BUS_IDLE);
      chk("ack", {15'h0000, ack_seen}, {15'h0000, rows[i].ack});
    end
    mode = CDH_IO;
    udma_on = 1'h0;
    n_wr = 0;
    run(5'h08);
    chk("io_wr", c_wr, taken);
    chk("n_wr", n_wr[15:0], 16'h0001);
    mode = CDH_MEM;
    n_wr = 0;
    run(5'h08);
    chk("mem_wr", n_wr[15:0], 16'h0000);
    mode = CDH_DISK;
    xfer_pending = 1'h1;
    c_rd = 16'h5AA5;
    got_rd = 16'h0000;
    run(5'h04);
    chk("dma_rd", got_rd, c_rd);
    run(5'h02);
    chk("dma_wr", c_wr, taken);
    chk("task", {15'h0000, task_access}, 16'h0000);
    drive_selected = 1'h0;
    repeat (3) @(negedge core_clk);
    chk("released", {15'h0000, cdh_if_i.req_oe_n}, 16'h0001);
    mode = CDH_IO;
    drive_selected = 1'h1;
    udma_on = 1'h1;
    burst_len = 8'h0A;
    bq.delete();
    n_stop = 0;
    fork
      run(5'h01);
      begin
        repeat (40) @(negedge core_clk);
        burst_pause = 1'h1;
        repeat (10) @(negedge core_clk);
        snap = bq.size();
        repeat (30) @(negedge core_clk);
        nb = bq.size();
        chk("pause", nb[15:0], snap[15:0]);
        burst_pause = 1'h0;
      end
    join
    nb = bq.size();
    chk("n_burst", nb[15:0], 16'h000A);
    for (int i = 1; i < nb; i++) chk("burst_word", bq[i] - bq[i-1], 16'h0111);
    chk("stopped", n_stop[15:0], 16'h0001);
    chk("ready", {15'h0000, host_ready}, 16'h0001);
    rx_ok = 1'h0;
    repeat (5) @(negedge core_clk);
    chk("not_ready", {15'h0000, host_ready}, 16'h0000);
    rx_ok = 1'h1;
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    chk("rst_grant", {15'h0000, cdh_if_i.transfer_grant_n}, 16'h0001);
    chk("rst_ack", {15'h0000, cdh_if_i.input_ack_n}, 16'h0001);
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
    chk("req_again", {15'h0000, cdh_if_i.transfer_request}, 16'h0001);
    end_of_test();
  end
endmodule // cdh_tb_top
`default_nettype wire
